// ---- rtl/sss_pkg.sv ----
package sss_pkg;

  // ----------------------------------------
  // Clocking and timebase
  // ----------------------------------------
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 10_000_000;
  localparam logic [5:0] OSC_MOD = 6'(SYS_CLK_HZ / 1_000_000);
  localparam logic [5:0] OSC_STEP = 6'(OSC_HZ / 1_000_000);
  localparam int FAST_TAP_PERIOD_NS = 200;
  localparam int NIB_W = 4;
  localparam int CHAIN_STAGES = 5;
  localparam int CHAIN_W = NIB_W * CHAIN_STAGES;
  localparam int SEQ_TAP = 9;
  localparam int SLOW_TAP_DEFAULT = 20;
  localparam int SEQ_TICK_NS = FAST_TAP_PERIOD_NS * (2 ** (SEQ_TAP - 1));
  localparam int SEQ_TICK_CYCLES = (SEQ_TICK_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

  // ----------------------------------------
  // Sequencer widths and limits
  // ----------------------------------------
  localparam int DLY_W = 8;
  localparam int ROT_W = 4;
  localparam logic [3:0] ROT_MIN = 4'h2;
  localparam logic [3:0] ROT_MAX = 4'hF;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h01020401;
  localparam int MSK_START_LSB = 0;
  localparam int MSK_PURGE_LSB = 8;
  localparam int MSK_LOAD_LSB = 16;
  localparam int MSK_STOP_LSB = 24;
  localparam int ST_RUN = 0;
  localparam int ST_EOR = 1;
  localparam int ST_PURGE = 2;
  localparam int ST_LOAD = 3;
  localparam int ST_SEQC = 4;
  localparam int ST_BRAKE = 5;
  localparam int ST_EMU = 6;
  localparam int ST_STP = 7;
  localparam int ST_ROT = 8;
  localparam int ST_SWITCH = 9;
  localparam int ST_PCLR = 10;
  localparam int ST_DLY_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- rtl/sss_top.sv ----
`timescale 1ns/10ps
module sss_top #(
  parameter int SLOW_TAP = sss_pkg::SLOW_TAP_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic POWER_CLEAR_IN,
  input wire logic PANEL_RUN_CONTACT,
  input wire logic PANEL_STOP_CONTACT,
  input wire logic HOST_START_STOP_LINE,
  input wire logic CART_INSERTED,
  input wire logic HEADS_RETRACTED,
  input wire logic BRUSHES_PARKED,
  input wire logic DISK_INDEX,
  input wire logic DISK_SPEED_OK,
  input wire logic HEADS_LOADED,
  input wire logic EMERGENCY_IN,
  output logic RUN_STATE,
  output logic PURGE_CYCLE,
  output logic LOAD_HEADS,
  output logic SEQ_COMPLETE,
  output logic BRAKE_CYCLE,
  output logic EMERGENCY_UNLOAD,
  output logic SEQ_TIMING_PULSE,
  output logic RUN_SWITCH_PULSE,
  output logic START_DRIVE_MOTOR_PULSE,
  output logic COUNTDOWN_TAP_NINE,
  output logic COUNTDOWN_TAP_TWENTY
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [5:0] acc_q;
  logic osc_tick;
  logic [3:0] nib_q [sss_pkg::CHAIN_STAGES];
  logic [sss_pkg::CHAIN_STAGES:0] nib_en;
  logic [sss_pkg::CHAIN_W-1:0] cnt;
  logic tap9_prev_q, slow_prev_q, seq_tick, slow_rise;
  logic pc_raw_q, pc_q, sw_q, merged, run_switch_pulse;
  logic [1:0] sr_q;
  logic run_q, run_d, eor_q, purge_q, load_q, seqc_q, brake_q, emu_q, stp_q, sdm_q;
  logic [sss_pkg::ROT_W-1:0] rot_q;
  logic idx_prev_q, disk_rot;
  logic [sss_pkg::DLY_W-1:0] dly_q, dly_mask;
  logic not_run_seq_term, seq_head_term, dly_rst, dec_hit, gated_tick;
  logic emerg_any, clear_or_unload, permit, stop_phase;
  logic [31:0] ctrl_q;
  logic aw_got_q, w_got_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ----------------------------------------
  // Reference and countdown chain
  // ----------------------------------------
  // Fractional divider gives a 10 MHz average tick
  assign osc_tick = (acc_q + sss_pkg::OSC_STEP) >= sss_pkg::OSC_MOD;

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      acc_q <= 6'h00;
    else if (osc_tick)
      acc_q <= acc_q + sss_pkg::OSC_STEP - sss_pkg::OSC_MOD;
    else
      acc_q <= acc_q + sss_pkg::OSC_STEP;
  end

  assign nib_en[0] = osc_tick;

  for (genvar i = 0; i < sss_pkg::CHAIN_STAGES; i++)
  begin : g_chain
    // Later stages step on the borrow of the stage below
    assign nib_en[i+1] = nib_en[i] && (nib_q[i] == 4'h0);
    assign cnt[i*sss_pkg::NIB_W +: sss_pkg::NIB_W] = nib_q[i];
    always_ff @(posedge SYS_CLK)
    begin
      if (SRST)
        nib_q[i] <= 4'h0;
      else if (nib_en[i])
        nib_q[i] <= nib_q[i] - 4'h1;
    end
  end

  // Tap n is counter bit n-1
  assign COUNTDOWN_TAP_NINE = cnt[sss_pkg::SEQ_TAP-1];
  assign COUNTDOWN_TAP_TWENTY = cnt[SLOW_TAP-1];
  // Common sequencer tick is the rising edge of tap nine
  assign seq_tick = cnt[sss_pkg::SEQ_TAP-1] && !tap9_prev_q;
  assign slow_rise = cnt[SLOW_TAP-1] && !slow_prev_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      tap9_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      tap9_prev_q <= cnt[sss_pkg::SEQ_TAP-1];
      slow_prev_q <= cnt[SLOW_TAP-1];
    end
  end

  // ----------------------------------------
  // Power clear and run/stop input
  // ----------------------------------------
  // Accept a new level only after two equal samples
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      pc_raw_q <= 1'b1;
      pc_q <= 1'b1;
    end
    else
    begin
      pc_raw_q <= POWER_CLEAR_IN;
      if (pc_raw_q == POWER_CLEAR_IN)
        pc_q <= POWER_CLEAR_IN;
    end
  end

  // Set/reset latch; both contacts or none holds state
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      sw_q <= 1'b0;
    else if (PANEL_RUN_CONTACT && !PANEL_STOP_CONTACT)
      sw_q <= 1'b1;
    else if (PANEL_STOP_CONTACT && !PANEL_RUN_CONTACT)
      sw_q <= 1'b0;
  end

  // Sources are ORed; either one toggles the request only while the other is low
  assign merged = sw_q | HOST_START_STOP_LINE;

  // Shift-register edge detector on the sequencer tick
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
      sr_q <= 2'b00;
    else if (seq_tick)
      sr_q <= {sr_q[0], merged};
  end

  assign run_switch_pulse = sr_q[0] ^ sr_q[1];

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  assign disk_rot = rot_q >= sss_pkg::ROT_MIN;
  // Timing pulse samples status during the start steps
  assign emerg_any = EMERGENCY_IN || (stp_q && purge_q && !DISK_SPEED_OK) || (stp_q && load_q && !HEADS_LOADED);
  assign clear_or_unload = pc_q || emerg_any;
  // Interlocks demand a full stop sequence before a new start
  assign permit = CART_INSERTED && HEADS_RETRACTED && BRUSHES_PARKED && !disk_rot && !brake_q && !seqc_q && !eor_q;

  // Next run state from state and commands
  always_comb
  begin
    run_d = run_q;
    // Faults force clear, else pulse toggles
    if (!CART_INSERTED || clear_or_unload)
      run_d = 1'b0;
    else if (run_switch_pulse)
      run_d = run_q ? 1'b0 : permit;
  end

  // Run flop loads run_d on every sequencer tick
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
      run_q <= 1'b0;
    else if (seq_tick)
      run_q <= run_d;
  end

  // Motor pulse only on a real set of run
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
      sdm_q <= 1'b0;
    else if (seq_tick)
      sdm_q <= run_switch_pulse && !run_q && run_d;
  end

  assign START_DRIVE_MOTOR_PULSE = sdm_q;

  // End-of-run catches the falling run edge
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
      eor_q <= 1'b0;
    else if (seq_tick)
      eor_q <= eor_q ? !seqc_q : (run_q && !run_d);
  end

  // Only the gated tap nine edge reaches purge and load
  assign gated_tick = seq_tick && stp_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      purge_q <= 1'b0;
      load_q <= 1'b0;
    end
    else if (gated_tick)
    begin
      purge_q <= run_q && !purge_q && !load_q && !seqc_q;
      load_q <= run_q && (purge_q || load_q) && !seqc_q;
    end
  end

  // Seqc set on start end or eor preset; brake takes over
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      seqc_q <= 1'b0;
      brake_q <= 1'b0;
    end
    else if (seq_tick)
    begin
      if (eor_q)
        seqc_q <= 1'b1;
      else if (stp_q && run_q && load_q)
        seqc_q <= 1'b1;
      else if (stp_q && !run_q && seqc_q)
        seqc_q <= 1'b0;
      if (stp_q && !run_q && seqc_q && !eor_q)
        brake_q <= 1'b1;
      else if (stp_q && !run_q && brake_q)
        brake_q <= 1'b0;
    end
  end

  // Unload preset by power clear, released at start end
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
      emu_q <= 1'b1;
    else if (seq_tick)
    begin
      if (emerg_any)
        emu_q <= 1'b1;
      else if (run_q && seqc_q)
        emu_q <= 1'b0;
    end
  end

  // Rotation counter; index pulses build, slow tap clears
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
    begin
      rot_q <= 4'h0;
      idx_prev_q <= 1'b0;
    end
    else
    begin
      idx_prev_q <= DISK_INDEX;
      if (slow_rise)
        rot_q <= 4'h0;
      else if (DISK_INDEX && !idx_prev_q && rot_q != sss_pkg::ROT_MAX)
        rot_q <= rot_q + 4'h1;
    end
  end

  // ----------------------------------------
  // Delay counter and decode
  // ----------------------------------------
  assign not_run_seq_term = !run_q && !seqc_q && !brake_q;
  assign seq_head_term = run_q && seqc_q;
  assign dly_rst = stp_q || not_run_seq_term || seq_head_term;

  // Two nibbles stepped by the slow tap
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || dly_rst)
      dly_q <= 8'h00;
    else if (slow_rise)
      dly_q <= dly_q + 8'h01;
  end

  assign stop_phase = !run_q && (seqc_q || brake_q);

  // Mask picked by state; hit when all chosen bits set
  always_comb
  begin
    dly_mask = 8'h00;
    if (stop_phase)
      dly_mask = ctrl_q[sss_pkg::MSK_STOP_LSB +: sss_pkg::DLY_W];
    else if (run_q && load_q)
      dly_mask = ctrl_q[sss_pkg::MSK_LOAD_LSB +: sss_pkg::DLY_W];
    else if (run_q && purge_q)
      dly_mask = ctrl_q[sss_pkg::MSK_PURGE_LSB +: sss_pkg::DLY_W];
    else if (run_q && !seqc_q)
      dly_mask = ctrl_q[sss_pkg::MSK_START_LSB +: sss_pkg::DLY_W];
  end

  // Zero mask disables the decode rather than firing at once
  assign dec_hit = (dly_mask != 8'h00) && ((dly_q & dly_mask) == dly_mask) && !eor_q;

  // J-K style pulse flop, one tick wide
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || pc_q)
      stp_q <= 1'b0;
    else if (seq_tick)
      stp_q <= dec_hit && !stp_q;
  end

  assign RUN_STATE = run_q;
  assign PURGE_CYCLE = purge_q;
  assign LOAD_HEADS = load_q;
  assign SEQ_COMPLETE = seqc_q;
  assign BRAKE_CYCLE = brake_q;
  assign EMERGENCY_UNLOAD = emu_q;
  assign SEQ_TIMING_PULSE = stp_q;
  assign RUN_SWITCH_PULSE = run_switch_pulse;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign S_AXI_AWREADY = !aw_got_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_got_q && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= sss_pkg::RESP_OKAY;
      ctrl_q <= sss_pkg::CTRL_RST;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (aw_got_q && w_got_q)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= sss_pkg::RESP_OKAY;
        if (awaddr_q == sss_pkg::CTRL_OFS)
        begin
          for (int b = 0; b < 4; b++)
            if (wstrb_q[b])
              ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        end
        else if (awaddr_q != sss_pkg::STATUS_OFS)
          S_AXI_BRESP <= sss_pkg::RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= sss_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= sss_pkg::RESP_OKAY;
      S_AXI_RDATA <= 32'h00000000;
      if (S_AXI_ARADDR == sss_pkg::CTRL_OFS)
        S_AXI_RDATA <= ctrl_q;
      else if (S_AXI_ARADDR == sss_pkg::STATUS_OFS)
      begin
        S_AXI_RDATA[sss_pkg::ST_RUN] <= run_q;
        S_AXI_RDATA[sss_pkg::ST_EOR] <= eor_q;
        S_AXI_RDATA[sss_pkg::ST_PURGE] <= purge_q;
        S_AXI_RDATA[sss_pkg::ST_LOAD] <= load_q;
        S_AXI_RDATA[sss_pkg::ST_SEQC] <= seqc_q;
        S_AXI_RDATA[sss_pkg::ST_BRAKE] <= brake_q;
        S_AXI_RDATA[sss_pkg::ST_EMU] <= emu_q;
        S_AXI_RDATA[sss_pkg::ST_STP] <= stp_q;
        S_AXI_RDATA[sss_pkg::ST_ROT] <= disk_rot;
        S_AXI_RDATA[sss_pkg::ST_SWITCH] <= merged;
        S_AXI_RDATA[sss_pkg::ST_PCLR] <= pc_q;
        S_AXI_RDATA[sss_pkg::ST_DLY_LSB +: sss_pkg::DLY_W] <= dly_q;
      end
      else
        S_AXI_RRESP <= sss_pkg::RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Cycles end-of-run has stood; one tick interval reaches the preset
  localparam logic [10:0] EOR_SPAN = 11'(sss_pkg::SEQ_TICK_CYCLES - 1);
  logic [10:0] eor_wait_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || !eor_q)
      eor_wait_q <= 11'h000;
    else if (eor_wait_q != 11'h7FF)
      eor_wait_q <= eor_wait_q + 11'h001;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_gate_hit;
    seq_tick && stp_q && run_q;
  endsequence

  sequence s_run_drop;
    seq_tick && run_q && !run_d && !pc_q;
  endsequence

  AST_TAP_ONE: assert property (osc_tick |=> cnt[0] != $past(cnt[0]))
    else $error("Tap one did not toggle on reference tick");
  AST_RIPPLE: assert property (osc_tick && nib_q[0] == 4'h0 |=> nib_q[1] == $past(nib_q[1]) - 4'h1)
    else $error("Second stage missed the borrow");
  AST_GATED: assert property (!gated_tick |=> $stable(purge_q) && $stable(load_q))
    else $error("Purge or load moved without gated clock");
  AST_DLY_RST: assert property (dly_rst |=> dly_q == 8'h00)
    else $error("Delay counter not reset");
  AST_PCLR: assert property (pc_q |=> !run_q && !eor_q && !stp_q && emu_q && rot_q == 4'h0 && sr_q == 2'b00)
    else $error("Power clear init incomplete");
  AST_DEBOUNCE: assert property (PANEL_STOP_CONTACT && !PANEL_RUN_CONTACT |=> !sw_q)
    else $error("Stop contact did not reset latch");
  AST_HOST_OR: assert property (seq_tick && HOST_START_STOP_LINE && !pc_q |=> sr_q[0])
    else $error("Host line not seen by pulse register");
  AST_PULSE_WIDTH: assert property (seq_tick && run_switch_pulse && merged == sr_q[0] && !pc_q |=> !run_switch_pulse)
    else $error("Run switch pulse longer than one tick");
  AST_SDM: assert property (seq_tick && !pc_q |=> sdm_q == ($past(run_switch_pulse) && !$past(run_q) && run_q))
    else $error("Start motor pulse without run set");
  AST_STP_WIDTH: assert property (seq_tick && stp_q && !pc_q |=> !stp_q)
    else $error("Timing pulse wider than one tick");
  AST_RUN_CLEAR: assert property (seq_tick && run_switch_pulse && run_q |=> !run_q)
    else $error("Run pulse did not clear run");
  AST_PURGE_LOAD: assert property (s_gate_hit ##0 purge_q && !seqc_q |=> load_q && !purge_q)
    else $error("Purge did not hand over to load");
  AST_STOP_ENTRY: assert property (s_run_drop |=> eor_q)
    else $error("Run drop did not set end-of-run");
  AST_STOP_PRESET: assert property (eor_q && eor_wait_q == EOR_SPAN |=> seqc_q)
    else $error("Stop entry did not preset sequence control");

endmodule

// ---- verif/sss_host_model.sv ----
`timescale 1ns/10ps
module sss_host_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic want_run,
  input wire logic slow,
  output logic line
);
  // ----------------------------------------
  // Host start/stop drive
  // ----------------------------------------
  int dly_q;
  always @(posedge clk)
  begin
    if (srst)
    begin
      line <= 1'h0;
      dly_q <= 0;
    end
    else if (want_run !== line)
    begin
      // Slow path mimics a busy controller
      if (dly_q >= (slow ? 37 : 0))
      begin
        line <= want_run;
        dly_q <= 0;
      end
      else
        dly_q <= dly_q + 1;
    end
    else
      dly_q <= 0;
  end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int TICK = 1280;
  localparam int SLOW = 4;
  logic SYS_CLK, SRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
  logic POWER_CLEAR_IN, PANEL_RUN_CONTACT, PANEL_STOP_CONTACT, HOST_START_STOP_LINE, CART_INSERTED, EMERGENCY_IN;
  logic RUN_STATE, PURGE_CYCLE, LOAD_HEADS, SEQ_COMPLETE, BRAKE_CYCLE, EMERGENCY_UNLOAD;
  logic SEQ_TIMING_PULSE, RUN_SWITCH_PULSE, START_DRIVE_MOTOR_PULSE, COUNTDOWN_TAP_NINE, COUNTDOWN_TAP_TWENTY;
  logic want_run, slow, mute, spin, DISK_INDEX;
  int rsp_n = 0, sdm_n = 0;
  int sdm_at;
  logic [4:0] mon;
  logic [5:0] st;
  int n_fail, samples_checked;
  int wcnt [5];
  // Tap twenty high half is tap one's 5 cycles doubled SLOW-1 times, halved
  int exp_w [5] = '{TICK, TICK, TICK, TICK / 2, 5 * (2 ** (SLOW - 2))};
  assign mon = {COUNTDOWN_TAP_TWENTY, COUNTDOWN_TAP_NINE, SEQ_TIMING_PULSE, START_DRIVE_MOTOR_PULSE, RUN_SWITCH_PULSE};
  assign st = {EMERGENCY_UNLOAD, BRAKE_CYCLE, SEQ_COMPLETE, LOAD_HEADS, PURGE_CYCLE, RUN_STATE};

  sss_top #(.SLOW_TAP(SLOW)) dut (.SYS_CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .POWER_CLEAR_IN, .PANEL_RUN_CONTACT, .PANEL_STOP_CONTACT, .HOST_START_STOP_LINE, .CART_INSERTED,
    .HEADS_RETRACTED(1'h1), .BRUSHES_PARKED(1'h1), .DISK_INDEX, .DISK_SPEED_OK(1'h1),
    .HEADS_LOADED(1'h1), .EMERGENCY_IN, .RUN_STATE, .PURGE_CYCLE, .LOAD_HEADS, .SEQ_COMPLETE, .BRAKE_CYCLE,
    .EMERGENCY_UNLOAD, .SEQ_TIMING_PULSE, .RUN_SWITCH_PULSE, .START_DRIVE_MOTOR_PULSE, .COUNTDOWN_TAP_NINE,
    .COUNTDOWN_TAP_TWENTY);

  sss_host_model host (.clk(SYS_CLK), .srst(SRST), .want_run(want_run), .slow(slow), .line(HOST_START_STOP_LINE));

  // ----------------------------------------
  // Compare and verdict
  // ----------------------------------------
  task cmp1(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cmp32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cmp_w(input int g, input int e);
    samples_checked++;
    if (g != e)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task summarize;
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    b_ok = 1'h0;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    while (!b_ok)
    begin
      @(posedge SYS_CLK);
      if (!aw_ok && S_AXI_AWREADY === 1'h1)
      begin
        aw_ok = 1'h1;
        S_AXI_AWVALID <= 1'h0;
      end
      if (!w_ok && S_AXI_WREADY === 1'h1)
      begin
        w_ok = 1'h1;
        S_AXI_WVALID <= 1'h0;
      end
      if (S_AXI_BVALID === 1'h1)
      begin
        b_ok = 1'h1;
        r = S_AXI_BRESP;
      end
    end
    S_AXI_BREADY <= 1'h0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    ar_ok = 1'h0;
    r_ok = 1'h0;
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    while (!r_ok)
    begin
      @(posedge SYS_CLK);
      if (!ar_ok && S_AXI_ARREADY === 1'h1)
      begin
        ar_ok = 1'h1;
        S_AXI_ARVALID <= 1'h0;
      end
      if (S_AXI_RVALID === 1'h1)
      begin
        r_ok = 1'h1;
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
      end
    end
    S_AXI_RREADY <= 1'h0;
  endtask

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    while (st[b] !== v && n < 8 * TICK)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    cmp1(st[b], v);
  endtask

  // ----------------------------------------
  // Pulse and tap width monitor
  // ----------------------------------------
  always @(posedge SYS_CLK)
  begin
    // Index edge every other cycle while the disk spins
    DISK_INDEX <= spin && !DISK_INDEX;
    if (RUN_SWITCH_PULSE === 1'h1)
      rsp_n <= rsp_n + 1;
    if (START_DRIVE_MOTOR_PULSE === 1'h1)
      sdm_n <= sdm_n + 1;
    for (int i = 0; i < 5; i++)
    begin
      if (SRST || mute)
        wcnt[i] = 0;
      else if (mon[i] === 1'h1)
        wcnt[i] = wcnt[i] + 1;
      else if (wcnt[i] > 0)
      begin
        cmp_w(wcnt[i], exp_w[i]);
        wcnt[i] = 0;
      end
    end
  end

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    SYS_CLK = 1'h0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  initial
  begin
    repeat (95000) @(posedge SYS_CLK);
    n_fail++;
    summarize;
  end

  initial
  begin
    {SRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = {8'h00, 32'h0, 4'hF};
    {POWER_CLEAR_IN, PANEL_RUN_CONTACT, PANEL_STOP_CONTACT, CART_INSERTED, EMERGENCY_IN} = 5'h00;
    {want_run, slow, mute, spin} = 4'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge SYS_CLK);
    SRST <= 1'h0;
    axi_read(sss_pkg::CTRL_OFS, rd, rs);
    cmp32(rd, sss_pkg::CTRL_RST);
    axi_write(sss_pkg::STATUS_OFS, 32'hFFFFFFFF, rs);
    cmp32(32'(rs), 32'(sss_pkg::RESP_OKAY));
    axi_read(sss_pkg::STATUS_OFS, rd, rs);
    cmp32(rd & 32'h000007FF, 32'h00000040);
    axi_write(4'h8, 32'h12345678, rs);
    cmp32(32'(rs), 32'(sss_pkg::RESP_SLVERR));
    axi_read(4'hC, rd, rs);
    cmp32({rd[29:0], rs}, {30'h0, sss_pkg::RESP_SLVERR});
    axi_write(sss_pkg::CTRL_OFS, 32'h03030303, rs);
    axi_read(sss_pkg::CTRL_OFS, rd, rs);
    cmp32(rd, 32'h03030303);
    // Cartridge out, emergency in: a bouncing panel press must not start the spindle
    EMERGENCY_IN <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge SYS_CLK);
      PANEL_RUN_CONTACT <= ~i[0];
      repeat (6) @(posedge SYS_CLK);
    end
    repeat (3 * TICK) @(posedge SYS_CLK);
    axi_read(sss_pkg::STATUS_OFS, rd, rs);
    cmp32(rd & 32'h00000201, 32'h00000200);
    cmp1(rsp_n > 0, 1'h1);
    cmp1(sdm_n == 0, 1'h1);
    PANEL_STOP_CONTACT <= 1'h1;
    repeat (7) @(posedge SYS_CLK);
    PANEL_STOP_CONTACT <= 1'h0;
    repeat (3 * TICK) @(posedge SYS_CLK);
    cmp1(RUN_STATE, 1'h0);
    // Host-driven start, slow host
    EMERGENCY_IN <= 1'h0;
    CART_INSERTED <= 1'h1;
    sdm_at = sdm_n;
    slow <= 1'h1;
    want_run <= 1'h1;
    wait_st(0, 1'h1);
    @(posedge SYS_CLK);
    cmp1(sdm_n > sdm_at, 1'h1);
    wait_st(1, 1'h1);
    cmp1(LOAD_HEADS | SEQ_COMPLETE, 1'h0);
    wait_st(2, 1'h1);
    cmp1(SEQ_COMPLETE, 1'h0);
    wait_st(3, 1'h1);
    wait_st(5, 1'h0);
    // Prompt stop request
    slow <= 1'h0;
    sdm_at = sdm_n;
    want_run <= 1'h0;
    wait_st(0, 1'h0);
    wait_st(4, 1'h1);
    cmp1(SEQ_COMPLETE, 1'h0);
    cmp1(sdm_n == sdm_at, 1'h1);
    wait_st(4, 1'h0);
    // Spinning disk refuses a start; the next level change starts it
    spin <= 1'h1;
    want_run <= 1'h1;
    repeat (3 * TICK) @(posedge SYS_CLK);
    cmp1(RUN_STATE, 1'h0);
    spin <= 1'h0;
    want_run <= 1'h0;
    // Power loss in the middle of a new start
    wait_st(0, 1'h1);
    mute <= 1'h1;
    POWER_CLEAR_IN <= 1'h1;
    repeat (6) @(posedge SYS_CLK);
    cmp1(RUN_STATE | SEQ_TIMING_PULSE | RUN_SWITCH_PULSE, 1'h0);
    cmp1(EMERGENCY_UNLOAD, 1'h1);
    summarize;
  end
endmodule
